// ==== design/motor_fault_pkg.sv ====
// Purpose: Shared constants and types of the motor fault response selector
// Assumes: 32-bit AHB-Lite register window, word accesses only
// Notes:   Response codes are 4-bit select fields held in the config register
`default_nettype none
package motor_fault_pkg;
    // ==============================================================
    // Clock and timing
    localparam int unsigned CLK_FREQ_MHZ = 200;        // 5 ns period
    localparam int unsigned MS_PER_US    = 1000;
    // ==============================================================
    // Register map (byte addresses)
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFF_CONFIG   = 8'h00;
    localparam logic [7:0]  OFF_THRESH   = 8'h04;
    localparam logic [7:0]  OFF_CONTROL  = 8'h08;
    localparam logic [7:0]  OFF_STATUS   = 8'h0C;
    // ==============================================================
    // Field layouts
    localparam int          MODE_W       = 4;
    localparam int          CFG_STALL    = 0;
    localparam int          CFG_PC       = 4;
    localparam int          CFG_SCUR     = 8;
    localparam int          CFG_PCCNT    = 16;
    localparam int          PCCNT_W      = 8;
    localparam int          LEVEL_W      = 12;
    localparam int          THR_PC       = 0;
    localparam int          THR_SCUR     = 16;
    localparam int          CTL_CLEAR    = 0;
    localparam int          STS_FLAGS    = 0;
    localparam int          STS_ACTION   = 4;
    localparam int          STS_LATCH    = 8;
    localparam int          STS_RETRY    = 9;
    localparam int          STS_HOLD     = 10;
    localparam int          NUM_SRC      = 3;
    localparam int          NUM_SLOW     = 2;
    localparam int          SRC_STALL    = 0;
    localparam int          SRC_SCUR     = 1;
    localparam int          SRC_PC       = 2;
    // ==============================================================
    // Reset values and bus codes
    localparam logic [31:0] CONFIG_RST   = 32'h0000_0000;
    localparam logic [31:0] THRESH_RST   = 32'h0FFF_0FFF;
    localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
    localparam logic [1:0]  HTRANS_IDLE  = 2'h0;
    localparam logic        HRESP_OKAY   = 1'b0;
    // ==============================================================
    // Types
    typedef logic [MODE_W-1:0] mode_t;
    typedef enum logic [2:0] {
        ACT_DRIVE    = 3'h0,
        ACT_RECIRC   = 3'h1,
        ACT_HIZ      = 3'h3,
        ACT_BRAKE_HI = 3'h2,
        ACT_BRAKE_LO = 3'h6
    } stage_action_t;
    typedef enum logic [2:0] {
        REC_NONE, REC_LATCH, REC_RETRY, REC_NEXT_PWM, REC_BELOW_THR, REC_COUNT
    } recovery_t;
    typedef struct packed {
        logic          report;
        stage_action_t action;
        recovery_t     recov;
    } response_t;
    typedef enum logic [1:0] {
        SLOW_IDLE  = 2'h0,
        SLOW_RETRY = 2'h1,
        SLOW_LATCH = 2'h3
    } slow_state_t;
    typedef enum logic {
        PC_IDLE = 1'b0,
        PC_HOLD = 1'b1
    } pc_state_t;
endpackage
`default_nettype wire

// ==== design/motor_fault_response_selector.sv ====
// Purpose: Fault response selection for stall, per-cycle and stall-current faults
// Assumes: Inputs synchronous to clk; single AHB-Lite master, zero wait states
// Notes:   Response selects are captured at detection and held for the whole fault
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module motor_fault_response_selector
    import motor_fault_pkg::*;
#(
    parameter int unsigned STALL_RETRY_TIME_US = 100_000
)(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic               abnormalSpeed,
    input  wire logic               noMotor,
    input  wire logic               lossOfSync,
    input  wire logic [LEVEL_W-1:0] currentSenseLevel,
    input  wire logic               pwmCycleStart,
    output var stage_action_t       stageAction,
    output logic                    fault_out_n
);
    // ==============================================================
    // Timing
    localparam longint unsigned RETRY_CYCLES = longint'(STALL_RETRY_TIME_US) * longint'(CLK_FREQ_MHZ);
    localparam logic [31:0]     RETRY_LOAD   = 32'(RETRY_CYCLES - 1);
    localparam logic [31:0]     TIMER_ZERO   = 32'h0000_0000;

    // Stall and stall-current select decode
    function automatic response_t decode_slow(input mode_t m, input logic isCurrent);
        response_t r;
        r = '{report: 1'b0, action: ACT_DRIVE, recov: REC_NONE};
        if (!m[3])
        begin
            r.report = 1'b1;
            r.recov  = m[2] ? REC_RETRY : REC_LATCH;
            unique case (m[1:0])
                2'b00: r.action = ACT_HIZ;
                2'b01: r.action = isCurrent ? ACT_RECIRC : ACT_HIZ;
                2'b10: r.action = ACT_BRAKE_HI;
                2'b11: r.action = ACT_BRAKE_LO;
            endcase
        end
        else if (m == 4'h8)
            r.report = 1'b1;
        return r;
    endfunction

    // Per-cycle select decode
    function automatic response_t decode_pc(input mode_t m);
        response_t r;
        r = '{report: 1'b0, action: ACT_DRIVE, recov: REC_NONE};
        if (!m[3] && m[2:0] != 3'h7)
        begin
            r.report = ~m[0];
            if (m[2:1] != 2'b11)
                r.action = ACT_RECIRC;
            unique case (m[2:1])
                2'b00: r.recov = REC_NEXT_PWM;
                2'b01: r.recov = REC_BELOW_THR;
                2'b10: r.recov = REC_COUNT;
                2'b11: r.recov = REC_NONE;
            endcase
        end
        return r;
    endfunction

    // ==============================================================
    // Register bus
    logic [31:0]        config_q;
    logic [31:0]        thresh_q;
    logic [NUM_SRC-1:0] flags_q;
    logic [NUM_SRC-1:0] flags_d;
    logic [NUM_SRC-1:0] reportEvt;
    logic               wrPend_q;
    logic [ADDR_W-1:0]  wrAddr_q;
    logic               clearPulse_q;
    logic [31:0]        status;
    logic               accept;
    slow_state_t        slowState_q [NUM_SLOW];
    response_t          slowResp_q  [NUM_SLOW];
    pc_state_t          pcState_q;
    response_t          pcResp_q;
    stage_action_t      selAction;

    assign accept = hsel && hready && htrans[1];

    // Address phase capture and read data
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wrPend_q <= 1'b0;
            wrAddr_q <= '0;
            hrdata   <= ZERO_WORD;
        end
        else
        begin
            wrPend_q <= accept && hwrite;
            if (accept)
                wrAddr_q <= haddr[ADDR_W-1:0];
            if (accept && !hwrite)
            begin
                unique case (haddr[ADDR_W-1:0])
                    OFF_CONFIG: hrdata <= config_q;
                    OFF_THRESH: hrdata <= thresh_q;
                    OFF_STATUS: hrdata <= status;
                    default:    hrdata <= ZERO_WORD;  // Control and unmapped
                endcase
            end
        end
    end

    // Zero wait state, always OKAY
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end
    end

    // Data phase writes; fault clear is a one-cycle pulse
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            config_q     <= CONFIG_RST;
            thresh_q     <= THRESH_RST;
            clearPulse_q <= 1'b0;
        end
        else
        begin
            clearPulse_q <= wrPend_q && wrAddr_q == OFF_CONTROL && hwdata[CTL_CLEAR];
            if (wrPend_q && wrAddr_q == OFF_CONFIG)
                config_q <= hwdata;
            if (wrPend_q && wrAddr_q == OFF_THRESH)
                thresh_q <= hwdata;
        end
    end

    // Status word
    always_comb
    begin
        status                              = ZERO_WORD;
        status[STS_FLAGS +: NUM_SRC]        = flags_q;
        status[STS_ACTION +: 3]             = stageAction;
        status[STS_LATCH]                   = slowState_q[SRC_STALL] == SLOW_LATCH
                                            || slowState_q[SRC_SCUR] == SLOW_LATCH;
        status[STS_RETRY]                   = slowState_q[SRC_STALL] == SLOW_RETRY
                                            || slowState_q[SRC_SCUR] == SLOW_RETRY;
        status[STS_HOLD]                    = pcState_q == PC_HOLD;
    end

    // ==============================================================
    // Fault detection
    mode_t              slowMode [NUM_SLOW];
    logic [NUM_SLOW-1:0] slowCond;
    logic               pcCond;
    logic [LEVEL_W-1:0] pcThr;

    assign slowMode[SRC_STALL] = config_q[CFG_STALL +: MODE_W];
    assign slowMode[SRC_SCUR]  = config_q[CFG_SCUR +: MODE_W];
    assign slowCond[SRC_STALL] = abnormalSpeed || noMotor || lossOfSync;
    assign slowCond[SRC_SCUR]  = currentSenseLevel > thresh_q[THR_SCUR +: LEVEL_W];
    assign pcThr               = thresh_q[THR_PC +: LEVEL_W];
    assign pcCond              = currentSenseLevel > pcThr;

    // ==============================================================
    // Stall and stall-current sequencers
    logic [31:0] retryTimer_q [NUM_SLOW];
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOW; gi++)
        begin : g_slow
            response_t respNow;
            assign respNow = decode_slow(slowMode[gi], gi == SRC_SCUR);
            assign reportEvt[gi] = slowState_q[gi] == SLOW_IDLE && slowCond[gi] && respNow.report;
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    slowState_q[gi]  <= SLOW_IDLE;
                    slowResp_q[gi]   <= '0;
                    retryTimer_q[gi] <= TIMER_ZERO;
                end
                else
                begin
                    unique case (slowState_q[gi])
                        SLOW_IDLE:
                        begin
                            if (slowCond[gi] && respNow.recov == REC_LATCH)
                            begin
                                slowState_q[gi] <= SLOW_LATCH;
                                slowResp_q[gi]  <= respNow;
                            end
                            else if (slowCond[gi] && respNow.recov == REC_RETRY)
                            begin
                                slowState_q[gi]  <= SLOW_RETRY;
                                slowResp_q[gi]   <= respNow;
                                retryTimer_q[gi] <= RETRY_LOAD;
                            end
                        end
                        SLOW_RETRY:
                        begin
                            if (retryTimer_q[gi] == TIMER_ZERO)
                                slowState_q[gi] <= SLOW_IDLE;
                            else
                                retryTimer_q[gi] <= retryTimer_q[gi] - 32'h0000_0001;
                        end
                        SLOW_LATCH:
                        begin
                            if (clearPulse_q)
                                slowState_q[gi] <= SLOW_IDLE;
                        end
                        default: slowState_q[gi] <= SLOW_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    // ==============================================================
    // Per-cycle current limit
    response_t          pcNow;
    logic [PCCNT_W-1:0] pcLimit_q;
    logic [PCCNT_W-1:0] pcCount_q;
    logic [PCCNT_W:0]   pcNext;

    assign pcNow               = decode_pc(config_q[CFG_PC +: MODE_W]);
    assign reportEvt[SRC_PC]   = pcState_q == PC_IDLE && pcCond && pcNow.report;
    assign pcNext              = {1'b0, pcCount_q} + 9'h001;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pcState_q <= PC_IDLE;
            pcResp_q  <= '0;
            pcLimit_q <= '0;
            pcCount_q <= '0;
        end
        else
        begin
            unique case (pcState_q)
                PC_IDLE:
                begin
                    if (pcCond && pcNow.action == ACT_RECIRC)
                    begin
                        pcState_q <= PC_HOLD;
                        pcResp_q  <= pcNow;
                        pcLimit_q <= config_q[CFG_PCCNT +: PCCNT_W];
                        pcCount_q <= '0;
                    end
                end
                PC_HOLD:
                begin
                    unique case (pcResp_q.recov)
                        REC_NEXT_PWM:
                            if (pwmCycleStart)
                                pcState_q <= PC_IDLE;
                        REC_BELOW_THR:
                            if (currentSenseLevel < pcThr)
                                pcState_q <= PC_IDLE;
                        REC_COUNT:
                            if (pwmCycleStart)
                            begin
                                pcCount_q <= pcNext[PCCNT_W-1:0];
                                if (pcNext > {1'b0, pcLimit_q})
                                    pcState_q <= PC_IDLE;
                            end
                        default: pcState_q <= PC_IDLE;
                    endcase
                end
            endcase
        end
    end

    // ==============================================================
    // Action priority: latched, retry, per-cycle hold, drive
    always_comb
    begin
        selAction = ACT_DRIVE;
        if (pcState_q == PC_HOLD)
            selAction = pcResp_q.action;
        for (int i = NUM_SLOW - 1; i >= 0; i--)
            if (slowState_q[i] == SLOW_RETRY)
                selAction = slowResp_q[i].action;
        for (int i = NUM_SLOW - 1; i >= 0; i--)
            if (slowState_q[i] == SLOW_LATCH)
                selAction = slowResp_q[i].action;
    end

    // Sticky flags; set wins over clear
    assign flags_d = (flags_q & ~{NUM_SRC{clearPulse_q}}) | reportEvt;

    // Flags, fault pin and power stage command
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            flags_q     <= '0;
            fault_out_n <= 1'b1;
            stageAction <= ACT_DRIVE;
        end
        else
        begin
            flags_q     <= flags_d;
            fault_out_n <= ~|flags_d;
            stageAction <= selAction;
        end
    end

    // ==============================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_stall_latch_hiz: assert property (
        slowState_q[0] == SLOW_IDLE && slowCond[0] && slowMode[0][3:1] == 3'h0
        |=> slowState_q[0] == SLOW_LATCH && !fault_out_n ##1 stageAction == ACT_HIZ)
        else $error("stall latch hi-z failed");
    chk_stall_brake_latch: assert property (
        slowState_q[0] == SLOW_IDLE && slowCond[0] && slowMode[0] == 4'h3
        |=> slowState_q[0] == SLOW_LATCH ##1 stageAction == ACT_BRAKE_LO)
        else $error("stall brake latch failed");
    chk_stall_retry_enter: assert property (
        slowState_q[0] == SLOW_IDLE && slowCond[0] && slowMode[0][3:1] == 3'h2
        |=> slowState_q[0] == SLOW_RETRY && slowResp_q[0].action == ACT_HIZ)
        else $error("stall retry entry failed");
    chk_retry_timer_end: assert property (
        slowState_q[0] == SLOW_RETRY && retryTimer_q[0] == TIMER_ZERO |=> slowState_q[0] == SLOW_IDLE)
        else $error("retry did not end at timer zero");
    chk_stall_report_only: assert property (
        slowState_q[0] == SLOW_IDLE && slowCond[0] && slowMode[0] == 4'h8
        |=> slowState_q[0] == SLOW_IDLE && flags_q[0] && !fault_out_n)
        else $error("stall report only failed");
    chk_stall_ignored: assert property (
        slowState_q[0] == SLOW_IDLE && lossOfSync && slowMode[0][3] && slowMode[0][0] && !flags_q[0]
        |=> slowState_q[0] == SLOW_IDLE && !flags_q[0])
        else $error("ignored stall acted");
    chk_pc_next_cycle: assert property (
        pcState_q == PC_HOLD && pcResp_q.recov == REC_NEXT_PWM && pwmCycleStart |=> pcState_q == PC_IDLE)
        else $error("per-cycle did not release at next PWM");
    chk_pc_below_thr: assert property (
        pcState_q == PC_HOLD && pcResp_q.recov == REC_BELOW_THR && currentSenseLevel >= pcThr
        |=> pcState_q == PC_HOLD)
        else $error("per-cycle released above threshold");
    chk_pc_count_hold: assert property (
        pcState_q == PC_HOLD && pcResp_q.recov == REC_COUNT && pcCount_q < pcLimit_q |=> pcState_q == PC_HOLD)
        else $error("per-cycle released before count");
    chk_scur_recirc_latch: assert property (
        slowState_q[1] == SLOW_IDLE && slowCond[1] && slowMode[1] == 4'h1
        |=> slowState_q[1] == SLOW_LATCH && slowResp_q[1].action == ACT_RECIRC)
        else $error("stall-current latch failed");
    chk_latch_until_clear: assert property (
        slowState_q[1] == SLOW_LATCH && !clearPulse_q |=> slowState_q[1] == SLOW_LATCH)
        else $error("latched fault left without clear");
    chk_latch_priority: assert property (
        slowState_q[0] == SLOW_LATCH ##1 slowState_q[0] == SLOW_LATCH |-> stageAction == slowResp_q[0].action)
        else $error("latched action not applied");
    chk_mode_frozen: assert property (
        slowState_q[1] != SLOW_IDLE ##1 slowState_q[1] != SLOW_IDLE |-> $stable(slowResp_q[1]))
        else $error("response changed mid-fault");

    cov_stall_retry: cover property (slowState_q[0] == SLOW_RETRY ##1 slowState_q[0] == SLOW_IDLE);
    cov_latch_clear: cover property (slowState_q[1] == SLOW_LATCH ##1 slowState_q[1] == SLOW_IDLE);
    cov_pc_count:    cover property (pcState_q == PC_HOLD && pcResp_q.recov == REC_COUNT ##1 pcState_q == PC_IDLE);
endmodule // motor_fault_response_selector
`default_nettype wire

// ==== test/pwm_source_model.sv ====
// Purpose: Power stage side model issuing PWM cycle start pulses
// Assumes: Bench raises kick for one cycle per pulse wanted
// Notes:   Pulse is one clk wide whatever the kick length
`timescale 1ns/1ps
`default_nettype none
module pwm_source_model
(
    input  wire logic clk,
    input  wire logic kick,
    output logic      pwmCycleStart
);
    // ==========================================
    // One pulse per one-cycle kick; a held kick pulses every other cycle, never two in a row
    always @(posedge clk)
        pwmCycleStart <= kick & ~pwmCycleStart;
endmodule // pwm_source_model
`default_nettype wire

// ==== test/motor_fault_response_selector_bench.sv ====
// Purpose: Self-checking bench of the motor fault response selector
// Assumes: Retry time parameter 1 us, so 200 cycles of retry
// Notes:   Stall codes 0 to 9, stall-current codes 0 to 8 and all 16 per-cycle codes are walked in turn
`timescale 1ns/1ps
`default_nettype none
module motor_fault_response_selector_bench;
    import motor_fault_pkg::*;
    logic          clk, rst, hsel, hwrite, hreadyout, hresp, kick, pwmCycleStart, fault_out_n;
    logic          abnormalSpeed, noMotor, lossOfSync;
    logic [31:0]   haddr, hwdata, hrdata, rd;
    logic [1:0]    htrans;
    logic [11:0]   currentSenseLevel;
    stage_action_t stageAction;
    int            fails = 0;
    int            cmp_count = 0;
    // ==========================================
    // Design and far-side model
    motor_fault_response_selector #(.STALL_RETRY_TIME_US(1)) u_dut (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .abnormalSpeed(abnormalSpeed), .noMotor(noMotor),
        .lossOfSync(lossOfSync), .currentSenseLevel(currentSenseLevel), .pwmCycleStart(pwmCycleStart),
        .stageAction(stageAction), .fault_out_n(fault_out_n));
    pwm_source_model u_pwm (.clk(clk), .kick(kick), .pwmCycleStart(pwmCycleStart));
    // ==========================================
    // Verdict, comparison and timing helpers
    task results;
        if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task ticks(input int n);
        repeat (n) @(posedge clk);
    endtask
    task waitRdy;
        int i;
        i = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1 && i < 50)
        begin
            i++;
            @(posedge clk);
        end
        if (i == 50)
        begin
            fails++;
            results();
        end
    endtask
    // Single AHB-Lite word transfer, read data lands in rd
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0000_00, a}; hwrite <= w; htrans <= 2'h2;
        waitRdy();
        hsel <= 1'b0; htrans <= HTRANS_IDLE; hwdata <= d;
        waitRdy();
        rd = hrdata;
        check(hresp, HRESP_OKAY);
    endtask
    // Clear and confirm the stage drives again
    task clearAll;
        bus(OFF_CONTROL, 1'b1, 32'h0000_0001);
        ticks(3);
        check(stageAction, ACT_DRIVE);
        check(fault_out_n, 1'b1);
    endtask
    // ==========================================
    // Stall (src 0) or stall-current (src 1) fault under select c
    task fault(input int src, input logic [3:0] c);
        stage_action_t a;
        case (c[1:0])
            2'h0: a = ACT_HIZ;
            2'h1: a = (src == 1) ? ACT_RECIRC : ACT_HIZ;
            2'h2: a = ACT_BRAKE_HI;
            default: a = ACT_BRAKE_LO;
        endcase
        if (c[3]) a = ACT_DRIVE;
        bus(OFF_CONFIG, 1'b1, (src == 1) ? {20'h0_0000, c, 8'h00} : {28'h000_0000, c});
        {abnormalSpeed, noMotor, lossOfSync} <= (src == 1) ? 3'h0 : 3'h1 << (c % 3);
        currentSenseLevel <= (src == 1) ? 12'h200 : 12'h000;
        ticks(3);
        check(stageAction, a);
        check(fault_out_n, c > 8);
        bus(OFF_STATUS, 1'b0, ZERO_WORD);
        check(rd[src], c <= 8);
        {abnormalSpeed, noMotor, lossOfSync} <= 3'h0;
        currentSenseLevel <= 12'h000;
        ticks(100);
        check(stageAction, a);
        ticks(110);
        check(stageAction, c[2] ? ACT_DRIVE : a);
        clearAll();
    endtask
    // Latched stall beside retrying stall-current; select rewritten mid-fault
    task prio;
        bus(OFF_CONFIG, 1'b1, 32'h0000_0600);
        lossOfSync <= 1'b1;
        currentSenseLevel <= 12'h200;
        ticks(3);
        check(stageAction, ACT_HIZ);
        bus(OFF_CONFIG, 1'b1, 32'h0000_0002);
        ticks(2);
        check(stageAction, ACT_HIZ);
        lossOfSync <= 1'b0;
        currentSenseLevel <= 12'h000;
        ticks(250);
        check(stageAction, ACT_HIZ);
        clearAll();
    endtask
    // ==========================================
    // Per-cycle limit under select c, recovery count 2
    task pc(input logic [3:0] c);
        bus(OFF_CONFIG, 1'b1, {8'h00, 8'h02, 8'h00, c, 4'h0});
        currentSenseLevel <= 12'h400;
        ticks(3);
        check(stageAction, (c < 6) ? ACT_RECIRC : ACT_DRIVE);
        check(fault_out_n, !(c < 7 && !c[0]));
        currentSenseLevel <= 12'h000;
        ticks(3);
        check(stageAction, (c == 2 || c == 3 || c > 5) ? ACT_DRIVE : ACT_RECIRC);
        for (int k = 1; k <= 3; k++)
        begin
            kick <= 1'b1;
            ticks(1);
            kick <= 1'b0;
            ticks(3);
            check(stageAction, (c inside {4, 5} && k < 3) ? ACT_RECIRC : ACT_DRIVE);
        end
        clearAll();
    endtask
    // ==========================================
    // Clock, hang guard and main sequence
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        ticks(50000);
        fails++;
        results();
    end
    initial
    begin
        rst = 1'b1; hsel = 1'b0; haddr = ZERO_WORD; htrans = HTRANS_IDLE; hwrite = 1'b0; hwdata = ZERO_WORD;
        {abnormalSpeed, noMotor, lossOfSync} = 3'h0; currentSenseLevel = 12'h000; kick = 1'b0;
        ticks(5);
        rst <= 1'b0;
        ticks(1);
        bus(OFF_THRESH, 1'b0, ZERO_WORD);
        check(rd, THRESH_RST);
        bus(OFF_CONFIG, 1'b0, ZERO_WORD);
        check(rd, CONFIG_RST);
        bus(8'h10, 1'b0, ZERO_WORD);
        check(rd, ZERO_WORD);
        bus(OFF_THRESH, 1'b1, 32'h0100_0FFF);
        for (int c = 0; c < 10; c++) fault(0, c[3:0]);
        for (int c = 0; c < 9; c++) fault(1, c[3:0]);
        prio();
        bus(OFF_THRESH, 1'b1, 32'h0800_0300);
        for (int c = 0; c < 16; c++) pc(c[3:0]);
        results();
    end
endmodule // motor_fault_response_selector_bench
`default_nettype wire
